// ---- ccd_pkg.sv ----
// constants, types and helpers shared by the cache operation dispatcher
`default_nettype none
package ccd_pkg;

   // ==========================================================
   // widths and instruction field positions
   localparam int INSTR_W = 32;
   localparam int ADDR_W  = 64;
   localparam int CCA_W   = 3;
   localparam int OP_W    = 3;
   localparam int NUM_LVL = 4;
   localparam int OP_HI   = 25;
   localparam int OP_LO   = 23;
   localparam int SEL_HI  = 22;
   localparam int SEL_LO  = 21;

   // ==========================================================
   // cache select codes
   localparam logic [1:0] SEL_PRI_INSTR = 2'h0;
   localparam logic [1:0] SEL_PRI_DATA  = 2'h1;
   localparam logic [1:0] SEL_TERTIARY  = 2'h2;
   localparam logic [1:0] SEL_SECONDARY = 2'h3;

   // ==========================================================
   // one-hot cache levels, inner to outer from bit 0 upward
   localparam logic [3:0] LVL_NONE = 4'h0;
   localparam logic [3:0] LVL_I    = 4'h1;
   localparam logic [3:0] LVL_D    = 4'h2;
   localparam logic [3:0] LVL_S    = 4'h4;
   localparam logic [3:0] LVL_T    = 4'h8;

   // ==========================================================
   // operation and coherency attribute tables, one bit per code
   localparam logic [7:0] OP_REQ_MASK    = 8'h03;
   localparam logic [7:0] OP_IMPL_MASK   = 8'hFF;
   localparam logic [7:0] OP_HIT_MASK    = 8'h70;
   localparam logic [7:0] CCA_COHERENT   = 8'h30;
   localparam logic       INCLUSIVE      = 1'b1;
   localparam logic       GLOBALIZE_EN   = 1'b1;

   // ==========================================================
   // dispatcher states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LEVEL,
      ST_BCAST,
      ST_DONE
   } ccd_state_t;

   // ==========================================================
   // helpers
   function automatic logic ccd_code_in(input logic [7:0] mask,
                                        input logic [2:0] code);
      ccd_code_in = mask[code];
   endfunction

   // innermost pending level; bit 0 is the innermost cache
   function automatic logic [3:0] ccd_lowest(input logic [3:0] m);
      ccd_lowest = m & (~m + LVL_I);
   endfunction

endpackage
`default_nettype wire

// ---- ccd_decode.sv ----
// field decoder of a cache maintenance instruction
`default_nettype none
`timescale 1ns/1ns
module ccd_decode (
   input  wire logic [ccd_pkg::INSTR_W-1:0] instr,
   input  wire logic [ccd_pkg::CCA_W-1:0]   coherency_attribute,
   output logic [ccd_pkg::OP_W-1:0]         maint_operation_field,
   output logic [3:0]                       target_level,
   output logic [3:0]                       level_mask,
   output logic                             globalize,
   output logic                             supported
);

   logic [1:0] sel;
   logic       hit_op;

   // ==========================================================
   // field extraction
   assign maint_operation_field =
      instr[ccd_pkg::OP_HI:ccd_pkg::OP_LO];
   assign sel = instr[ccd_pkg::SEL_HI:ccd_pkg::SEL_LO];

   // required codes are always present whatever the option table says
   assign supported = ccd_pkg::ccd_code_in(
      ccd_pkg::OP_IMPL_MASK | ccd_pkg::OP_REQ_MASK,
      maint_operation_field);

   always_comb begin
      case (sel)
         ccd_pkg::SEL_PRI_INSTR: target_level = ccd_pkg::LVL_I;
         ccd_pkg::SEL_PRI_DATA:  target_level = ccd_pkg::LVL_D;
         ccd_pkg::SEL_TERTIARY:  target_level = ccd_pkg::LVL_T;
         ccd_pkg::SEL_SECONDARY: target_level = ccd_pkg::LVL_S;
         default:                target_level = ccd_pkg::LVL_NONE;
      endcase
   end

   // outer levels pull in the data side inner levels when inclusive
   always_comb begin
      level_mask = target_level;
      if (ccd_pkg::INCLUSIVE) begin
         if (target_level == ccd_pkg::LVL_S) begin
            level_mask = ccd_pkg::LVL_D | ccd_pkg::LVL_S;
         end else if (target_level == ccd_pkg::LVL_T) begin
            level_mask = ccd_pkg::LVL_D | ccd_pkg::LVL_S | ccd_pkg::LVL_T;
         end
      end
   end

   // ==========================================================
   // one globalize decision for the whole instruction
   assign hit_op = ccd_pkg::ccd_code_in(ccd_pkg::OP_HIT_MASK,
                                        maint_operation_field);
   assign globalize = ccd_pkg::GLOBALIZE_EN & hit_op &
      ccd_pkg::ccd_code_in(ccd_pkg::CCA_COHERENT,
                           coherency_attribute);

endmodule
`default_nettype wire

// ---- ccd_dispatch.sv ----
// cache maintenance dispatcher: sequences levels and broadcast
`default_nettype none
`timescale 1ns/1ns
// Behaviour
// - operation is taken from instruction bits 25 to 23.
// - all required operation codes are implemented; others optional.
// - inclusive outer-level operation is first applied to inner levels (code pulls in D, plus S for tertiary, never I).
// - hit-type operations may act on all coherent caches.
// - coherent attribute globalizes the operation by broadcast.
// - non-coherent attribute means no broadcast at all.
// - all affected levels use the same global or local behaviour.
// - cache select bits 22 to 21: I, D, tertiary, secondary.
// - maintenance and its transfers complete like a memory barrier.
module ccd_dispatch (
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   // ==========================================================
   // issuing pipeline
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire logic [ccd_pkg::INSTR_W-1:0] req_instr,
   input  wire logic [ccd_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [ccd_pkg::CCA_W-1:0]   req_coherency_attribute,
   output logic                             done,
   output logic                             done_error,
   output logic                             busy,
   // ==========================================================
   // local cache levels, one-hot request held until acknowledged
   output logic [3:0]                       lvl_req,
   output logic [ccd_pkg::OP_W-1:0]         lvl_op,
   output logic [ccd_pkg::ADDR_W-1:0]       lvl_addr,
   output logic                             lvl_global,
   input  wire logic [3:0]                  lvl_ack,
   // ==========================================================
   // coherent interconnect broadcast
   output logic                             bcast_valid,
   output logic [ccd_pkg::OP_W-1:0]         bcast_op,
   output logic [ccd_pkg::ADDR_W-1:0]       bcast_addr,
   output logic [3:0]                       bcast_levels,
   input  wire logic                        bcast_ack
);

   // ==========================================================
   // state
   typedef struct packed {
      ccd_pkg::ccd_state_t             state;
      logic [3:0]                      pending;
      logic [3:0]                      levels;
      logic [3:0]                      cur;
      logic [ccd_pkg::OP_W-1:0]        op;
      logic [ccd_pkg::ADDR_W-1:0]      addr;
      logic                            glob;
      logic                            err;
      logic                            bcast;
   } ccd_regs_t;

   ccd_regs_t                          s;
   ccd_regs_t                          next_s;

   logic [ccd_pkg::OP_W-1:0]           dec_op;
   logic [3:0]                         dec_target;
   logic [3:0]                         dec_mask;
   logic                               dec_global;
   logic                               dec_supported;
   logic [3:0]                         remaining;

   // ==========================================================
   // decoder
   ccd_decode u_decode (
      .instr                 (req_instr),
      .coherency_attribute   (req_coherency_attribute),
      .maint_operation_field (dec_op),
      .target_level          (dec_target),
      .level_mask            (dec_mask),
      .globalize             (dec_global),
      .supported             (dec_supported)
   );

   assign remaining = s.pending & ~s.cur;

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;
      case (s.state)
         ccd_pkg::ST_IDLE: begin
            // one instruction at a time keeps barrier-like ordering
            if (req_valid) begin
               next_s.op      = dec_op;
               next_s.addr    = req_addr;
               next_s.levels  = dec_mask;
               next_s.pending = dec_mask;
               // latched once so every level sees the same choice
               next_s.glob    = dec_global;
               next_s.err     = ~dec_supported;
               if (!dec_supported || dec_mask == ccd_pkg::LVL_NONE) begin
                  next_s.state = ccd_pkg::ST_DONE;
                  next_s.cur   = ccd_pkg::LVL_NONE;
               end else begin
                  next_s.state = ccd_pkg::ST_LEVEL;
                  next_s.cur   = ccd_pkg::ccd_lowest(dec_mask);
               end
            end
         end
         ccd_pkg::ST_LEVEL: begin
            // a level acks only after its own writebacks have drained
            if ((lvl_ack & s.cur) != ccd_pkg::LVL_NONE) begin
               next_s.pending = remaining;
               if (remaining != ccd_pkg::LVL_NONE) begin
                  next_s.cur = ccd_pkg::ccd_lowest(remaining);
               end else begin
                  next_s.cur = ccd_pkg::LVL_NONE;
                  if (s.glob) begin
                     next_s.state = ccd_pkg::ST_BCAST;
                     next_s.bcast = 1'b1;
                  end else begin
                     next_s.state = ccd_pkg::ST_DONE;
                  end
               end
            end
         end
         ccd_pkg::ST_BCAST: begin
            if (bcast_ack) begin
               next_s.bcast = 1'b0;
               next_s.state = ccd_pkg::ST_DONE;
            end
         end
         ccd_pkg::ST_DONE: begin
            next_s.state = ccd_pkg::ST_IDLE;
         end
         default: begin
            next_s.state = ccd_pkg::ST_IDLE;
            next_s.cur   = ccd_pkg::LVL_NONE;
            next_s.bcast = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs
   assign req_ready    = (s.state == ccd_pkg::ST_IDLE);
   // done only when every level and every recipient has finished
   assign done         = (s.state == ccd_pkg::ST_DONE);
   assign done_error   = s.err;
   assign busy         = (s.state != ccd_pkg::ST_IDLE);
   assign lvl_req      = s.cur;
   assign lvl_op       = s.op;
   assign lvl_addr     = s.addr;
   assign lvl_global   = s.glob;
   assign bcast_valid  = s.bcast;
   assign bcast_op     = s.op;
   assign bcast_addr   = s.addr;
   // remote caches get the same level set, handled globally throughout
   assign bcast_levels = s.levels;

endmodule
`default_nettype wire

// ---- ccd_far_model.sv ----
// far-side model: cache levels and coherent interconnect
`timescale 1ns/1ns
`default_nettype none
module ccd_far_model (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] lvl_req,
   input  wire logic       bcast_valid,
   input  wire logic [1:0] dly,
   input  wire logic       noise,
   output logic [3:0]      lvl_ack,
   output logic            bcast_ack
);
   logic [1:0] lcnt;
   logic [1:0] bcnt;
   // ==========================================================
   // wait counters; dly stands for writeback and snoop time
   always_ff @(posedge core_clk) begin
      if (reset || lvl_req == 4'h0 || (lvl_req & lvl_ack) != 4'h0)
         lcnt <= 2'h0;
      else if (lcnt != dly)
         lcnt <= lcnt + 2'h1;
      if (reset || !bcast_valid || bcast_ack)
         bcnt <= 2'h0;
      else if (bcnt != dly)
         bcnt <= bcnt + 2'h1;
   end
   // ack means the level is finished, writebacks included
   // noise acks foreign levels to prove they are ignored
   // levels acked in the order asked; inner-first issue is the design's
   // job here, so the issuer need not mimic it
   assign lvl_ack = (lvl_req != 4'h0 && lcnt == dly) ? lvl_req
                  : (noise ? ~lvl_req : 4'h0);
   // ack only counts while valid, so noise may pulse it when idle
   assign bcast_ack = bcast_valid ? (bcnt == dly) : noise;
endmodule
`default_nettype wire

// ---- ccd_monitor.sv ----
// assertion checker for the cache maintenance dispatcher
`timescale 1ns/1ns
`default_nettype none
module ccd_monitor (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [31:0] req_instr,
   input wire logic [2:0]  req_coherency_attribute,
   input wire logic        done,
   input wire logic [3:0]  lvl_req,
   input wire logic [2:0]  lvl_op,
   input wire logic        lvl_global,
   input wire logic [3:0]  lvl_ack,
   input wire logic        bcast_valid,
   input wire logic        bcast_ack
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic take = req_valid && req_ready;
   wire logic glob = ccd_pkg::CCA_COHERENT[req_coherency_attribute]
                   && ccd_pkg::OP_HIT_MASK[req_instr[25:23]];
   // ==========================================================
   property p_code; take |=> lvl_op == $past(req_instr[25:23]); endproperty
   a_code: assert property (p_code)
      else $error("operation code not taken from bits 25 to 23");
   property p_first;
      take |=> lvl_req == ($past(req_instr[22:21]) == 2'h0 ? 4'h1 : 4'h2);
   endproperty
   a_first: assert property (p_first)
      else $error("first level is not the innermost one");
   property p_held;
      lvl_req != 4'h0 && (lvl_req & lvl_ack) == 4'h0 |=> $stable(lvl_req);
   endproperty
   a_held: assert property (p_held)
      else $error("level request dropped before its ack");
   property p_coh; take && glob |-> ##[2:60] bcast_valid; endproperty
   a_coh: assert property (p_coh)
      else $error("coherent hit operation not broadcast");
   property p_loc; take && !glob |=> !bcast_valid until done; endproperty
   a_loc: assert property (p_loc)
      else $error("local operation was broadcast");
   property p_glob; take |=> lvl_global == $past(glob); endproperty
   a_glob: assert property (p_glob)
      else $error("global flag differs from the decision");
   property p_after; bcast_valid |-> lvl_req == 4'h0; endproperty
   a_after: assert property (p_after)
      else $error("broadcast overlaps a local level");
   property p_bound; take |-> ##[1:60] done; endproperty
   a_bound: assert property (p_bound)
      else $error("operation never completed");
   property p_cause;
      $rose(done) |-> $past(bcast_valid && bcast_ack)
                   || $past((lvl_req & lvl_ack) != 4'h0);
   endproperty
   a_cause: assert property (p_cause)
      else $error("done without a final acknowledge");
endmodule
bind ccd_dispatch ccd_monitor u_ccd_monitor (
   .core_clk(core_clk), .reset(reset), .req_valid(req_valid),
   .req_ready(req_ready), .req_instr(req_instr), .done(done),
   .req_coherency_attribute(req_coherency_attribute), .lvl_req(lvl_req),
   .lvl_op(lvl_op), .lvl_global(lvl_global), .lvl_ack(lvl_ack),
   .bcast_valid(bcast_valid), .bcast_ack(bcast_ack));
`default_nettype wire

// ---- cache_op_dispatch_bench.sv ----
// self-checking bench of the cache maintenance dispatcher
`timescale 1ns/1ns
`default_nettype none
module cache_op_dispatch_bench;
   typedef struct packed {
      logic [2:0] code;
      logic [1:0] sel;
      logic [2:0] attr;
      logic [3:0] lv;
      logic       bc;
   } ccd_row_t;
   logic        core_clk, reset, req_valid, req_ready, done, done_error;
   logic        busy, lvl_global, bcast_valid, bcast_ack, noise;
   logic [31:0] req_instr;
   logic [63:0] req_addr, lvl_addr, bcast_addr;
   logic [2:0]  req_coherency_attribute, lvl_op, bcast_op;
   logic [3:0]  lvl_req, lvl_ack, bcast_levels;
   logic [1:0]  dly;
   int          mismatches, cmp_count;
   ccd_row_t    rows [10] = '{
      '{3'h0, 2'h0, 3'h0, 4'h1, 1'b0}, '{3'h1, 2'h1, 3'h4, 4'h2, 1'b0},
      '{3'h2, 2'h2, 3'h5, 4'hE, 1'b0}, '{3'h3, 2'h3, 3'h0, 4'h6, 1'b0},
      '{3'h4, 2'h1, 3'h4, 4'h2, 1'b1}, '{3'h5, 2'h3, 3'h5, 4'h6, 1'b1},
      '{3'h6, 2'h2, 3'h4, 4'hE, 1'b1}, '{3'h7, 2'h2, 3'h4, 4'hE, 1'b0},
      '{3'h4, 2'h3, 3'h3, 4'h6, 1'b0}, '{3'h6, 2'h0, 3'h5, 4'h1, 1'b1}};
   ccd_dispatch u_ccd_dispatch (
      .core_clk(core_clk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_instr(req_instr), .req_addr(req_addr),
      .req_coherency_attribute(req_coherency_attribute), .done(done),
      .done_error(done_error), .busy(busy), .lvl_req(lvl_req),
      .lvl_op(lvl_op), .lvl_addr(lvl_addr), .lvl_global(lvl_global),
      .lvl_ack(lvl_ack), .bcast_valid(bcast_valid), .bcast_op(bcast_op),
      .bcast_addr(bcast_addr), .bcast_levels(bcast_levels),
      .bcast_ack(bcast_ack));
   ccd_far_model u_ccd_far_model (
      .core_clk(core_clk), .reset(reset), .lvl_req(lvl_req),
      .bcast_valid(bcast_valid), .dly(dly), .noise(noise),
      .lvl_ack(lvl_ack), .bcast_ack(bcast_ack));
   // ==========================================================
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic cmp1(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t levels got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_word(input logic [63:0] g, input logic [63:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t word got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d of %0d compares", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk_idle();
      cmp1(req_ready, 1'b1);
      cmp1(busy, 1'b0);
      cmp4(lvl_req, 4'h0);
      cmp1(bcast_valid, 1'b0);
   endtask
   // one instruction at a time, collecting what the far side saw
   task automatic run_row(input ccd_row_t r);
      logic [3:0] seen, first, prev, bl;
      logic       bc, ord_ok, lg;
      logic [63:0] la, ba, ea;
      logic [2:0] lo, bo;
      int         n, m;
      req_instr = {6'h0, r.code, r.sel, 21'h0};
      req_coherency_attribute = r.attr;
      req_addr = {56'h0, r.code, r.sel, r.attr};
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      {seen, first, prev, bl, bc, ord_ok} = 18'h1;
      ea = {56'h0, r.code, r.sel, r.attr};
      la = 64'h0;
      ba = 64'h0;
      lo = 3'h0;
      bo = 3'h0;
      lg = 1'b0;
      m = 0;
      while (done !== 1'b1 && n < 200) begin
         if (lvl_req !== 4'h0) begin
            if (first === 4'h0)
               first = lvl_req;
            if (lvl_req < prev)
               ord_ok = 1'b0;
            prev = lvl_req;
            seen = seen | lvl_req;
            la = lvl_addr;
            lo = lvl_op;
            lg = lvl_global;
         end
         if (bcast_valid === 1'b1) begin
            bc = 1'b1;
            bl = bcast_levels;
            bo = bcast_op;
            ba = bcast_addr;
         end
         @(posedge core_clk);
         #1;
         n++;
         m++;
      end
      cmp1(done, 1'b1);
      cmp1(done_error, 1'b0);
      cmp4(first, r.sel == 2'h0 ? 4'h1 : 4'h2);
      cmp1(ord_ok, 1'b1);
      cmp4(seen, r.lv);
      cmp1(bc, r.bc);
      cmp4(bl, r.bc ? r.lv : 4'h0);
      cmp1(lg, r.bc);
      cmp_word(64'(lo), 64'(r.code));
      cmp_word(la, ea);
      cmp_word(64'(bo), r.bc ? 64'(r.code) : 64'h0);
      cmp_word(ba, r.bc ? ea : 64'h0);
      // each level and the broadcast take dly+1 edges in the far model
      cmp_word(64'(m),
               64'(($countones(r.lv) + int'(r.bc)) * (int'(dly) + 1)));
   endtask
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_instr = 32'h0;
      req_addr = 64'h0;
      req_coherency_attribute = 3'h0;
      dly = 2'h0;
      noise = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      repeat (10) @(posedge core_clk);
      #1;
      chk_idle();
      reset = 1'b0;
      for (int i = 0; i < 10; i++) begin
         dly = 2'(i % 3);
         noise = i[0];
         run_row(rows[i]);
      end
      // reset in mid-sequence, then a full instruction to show recovery
      dly = 2'h3;
      req_instr = 32'h0340_0000;
      req_coherency_attribute = 3'h4;
      repeat (2) @(posedge core_clk);
      #1;
      req_valid = 1'b1;
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      cmp1(busy, 1'b1);
      reset = 1'b1;
      @(posedge core_clk);
      #1;
      chk_idle();
      reset = 1'b0;
      run_row(rows[5]);
      stop_test();
   end
   // the whole run needs about a hundred cycles; 20000 means a hang
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
endmodule
`default_nettype wire
